/* File: hdl/rif_irq_flags.sv */
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Tx pin one: data clock in continuous, else FIFO-full or tx-done by select
// - FIFO-full flag reads high while FIFO holds its configured byte count
// - Active-high not-empty flag reads low when FIFO is empty
// - Buffered mode: fill method picks sync-word start or manual fill control
// - Auto fill: fill bit goes high once sync word detected and loading begins
// - Auto fill: writing one clears fill bit and re-arms, unless overrun set
// - Manual fill: writing one starts loading, zero stops it
// - Tx-done flag sets when last bit leaves the output shift register
// - Overrun flag sets on every FIFO overrun error
// - Writing one to overrun clears it and launches a fresh process
// - Level interrupt source enable resets to zero, disabling that source
// - Level flag sets above threshold, cleared by writing one
// - Lock flag sets on lock, cleared by writing one
// - Lock-detect enable resets to one; when zero the lock pin is high
// - Eight-bit level threshold, same units as measurement, resets to zero
module rif_irq_flags
    import rif_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire rif_bus_req_t bus_req,
    output logic [7:0] rdata,
    // Data path status
    input wire logic [1:0] data_mode,
    input wire logic tx_mode,
    input wire logic recovered_data_clock,
    input wire rif_fifo_t fifo_state,
    input wire rif_evt_t evt,
    input wire logic [7:0] signal_level,
    // Synthesizer lock from the analog side
    input wire logic pll_lock_pin,
    // Pins and controls
    output logic interrupt_pin_one,
    output logic lock_detect_pin,
    output logic fifo_load_en,
    output logic restart,
    output logic irq
);

    // Register state
    logic [4:0] src_hi_ff;
    logic tx_sel_ff;
    logic fill_method_ff;
    rif_fill_state_t fill_state_ff;
    rif_fill_state_t nxt_fill_state;
    logic tx_done_ff;
    logic ovr_ff;
    logic lvl_en_ff;
    logic lvl_flag_ff;
    logic lock_flag_ff;
    logic lock_en_ff;
    logic [7:0] thresh_ff;
    logic [4:0] status_ff;
    logic [4:0] enable_ff;
    logic lock_s1_ff;
    logic lock_s2_ff;
    logic lock_d_ff;
    logic tx_mode_d_ff;
    logic [7:0] rdata_ff;
    logic pin_one_ff;
    logic lock_pin_ff;
    logic load_en_ff;
    logic restart_ff;
    logic irq_ff;

    // Address decode
    wire hit_cfg = bus_req.addr == RIF_ADDR_SRC_CFG;
    wire hit_ctl = bus_req.addr == RIF_ADDR_STAT_CTL;
    wire hit_thr = bus_req.addr == RIF_ADDR_THRESH;
    wire hit_sts = bus_req.addr == RIF_ADDR_IRQ_STATUS;
    wire hit_clr = bus_req.addr == RIF_ADDR_IRQ_CLEAR;
    wire hit_ena = bus_req.addr == RIF_ADDR_IRQ_ENABLE;
    wire wr_cfg = bus_req.wr && hit_cfg;
    wire wr_ctl = bus_req.wr && hit_ctl;
    wire wr_thr = bus_req.wr && hit_thr;
    wire wr_clr = bus_req.wr && hit_clr;
    wire wr_ena = bus_req.wr && hit_ena;

    // Write-one-clear strobes of the control register
    wire ovr_clr = wr_ctl && bus_req.wdata[RIF_OVR_BIT];
    wire lvl_clr = wr_ctl && bus_req.wdata[RIF_LVL_FLAG_BIT];
    wire lock_clr = wr_ctl && bus_req.wdata[RIF_LOCK_FLAG_BIT];
    wire fill_wr1 = wr_ctl && bus_req.wdata[RIF_FILL_BIT];

    // FIFO occupancy flags
    wire fifo_full = fifo_state.count == fifo_state.capacity;
    wire fifo_nempty = fifo_state.count != 7'h00;

    // Mode decode
    wire buffered = data_mode == RIF_MODE_BUF;
    wire continuous = data_mode == RIF_MODE_CONT;
    wire auto_fill = buffered && !fill_method_ff;
    wire manual_fill = buffered && fill_method_ff;

    // Level compare, gated by the source enable
    wire lvl_hit = lvl_en_ff && (signal_level > thresh_ff);

    // Lock rising edge from the synchronised level
    wire lock_rise = lock_s2_ff && !lock_d_ff;

    // Fill start seen by the interrupt logic
    wire fill_start = auto_fill && (fill_state_ff == RIF_FS_WAIT) && evt.sync_detect;

    // Events that set sticky interrupt status bits
    wire [4:0] ev_vec = {fill_start, lock_rise, lvl_hit && !lvl_flag_ff,
                         evt.last_bit_out, evt.overrun};
    wire [4:0] nxt_status = (status_ff & ~(wr_clr ? bus_req.wdata[4:0] : 5'h00)) | ev_vec;

    // FIFO fill state selection; a sync word beats a re-arm write in the same cycle
    always_comb
    begin
        nxt_fill_state = fill_state_ff;
        if (ovr_clr)
            nxt_fill_state = RIF_FS_WAIT;
        else if (manual_fill && wr_ctl)
            nxt_fill_state = fill_wr1 ? RIF_FS_LOAD : RIF_FS_WAIT;
        else if (fill_start)
            nxt_fill_state = RIF_FS_LOAD;
        else if (auto_fill && fill_wr1 && !ovr_ff)
            nxt_fill_state = RIF_FS_WAIT;
    end

    // Pin one source in transmit mode
    wire tx_pin_src = tx_sel_ff ? tx_done_ff : fifo_full;
    wire nxt_pin_one = tx_mode && (continuous ? recovered_data_clock : tx_pin_src);

    // Lock pin is held high while detection is disabled
    wire nxt_lock_pin = lock_en_ff ? lock_s2_ff : 1'b1;

    // Register readback views
    wire fill_bit = fill_state_ff == RIF_FS_LOAD;
    wire [7:0] rd_cfg = {src_hi_ff, tx_sel_ff, fifo_full, fifo_nempty};
    wire [7:0] rd_ctl = {fill_method_ff, fill_bit, tx_done_ff, ovr_ff,
                         lvl_en_ff, lvl_flag_ff, lock_flag_ff, lock_en_ff};
    wire [7:0] rd_mux = hit_cfg ? rd_cfg :
                        hit_ctl ? rd_ctl :
                        hit_thr ? thresh_ff :
                        hit_sts ? {3'h0, status_ff} :
                        hit_ena ? {3'h0, enable_ff} : 8'h00;

    // Two-stage synchroniser for the lock input, then edge history
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lock_s1_ff <= 1'b0;
            lock_s2_ff <= 1'b0;
            lock_d_ff <= 1'b0;
        end
        else
        begin
            lock_s1_ff <= pll_lock_pin;
            lock_s2_ff <= lock_s1_ff;
            lock_d_ff <= lock_s2_ff;
        end
    end

    // Configuration storage
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            src_hi_ff <= RIF_SRC_HI_RST;
            tx_sel_ff <= RIF_TX_SEL_RST;
            fill_method_ff <= RIF_FILL_METHOD_RST;
            lvl_en_ff <= RIF_LVL_EN_RST;
            lock_en_ff <= RIF_LOCK_EN_RST;
            thresh_ff <= RIF_THRESH_RST;
            enable_ff <= RIF_EV_RST;
        end
        else
        begin
            if (wr_cfg)
            begin
                src_hi_ff <= bus_req.wdata[7:3];
                tx_sel_ff <= bus_req.wdata[RIF_TX_SEL_BIT];
            end
            if (wr_ctl)
            begin
                fill_method_ff <= bus_req.wdata[RIF_FILL_METHOD_BIT];
                lvl_en_ff <= bus_req.wdata[RIF_LVL_EN_BIT];
                lock_en_ff <= bus_req.wdata[RIF_LOCK_EN_BIT];
            end
            if (wr_thr)
                thresh_ff <= bus_req.wdata;
            if (wr_ena)
                enable_ff <= bus_req.wdata[4:0];
        end
    end

    // Sticky flags: a set in the cycle of a clear wins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ovr_ff <= 1'b0;
            lvl_flag_ff <= 1'b0;
            lock_flag_ff <= 1'b0;
            tx_done_ff <= 1'b0;
            tx_mode_d_ff <= 1'b0;
        end
        else
        begin
            ovr_ff <= evt.overrun || (ovr_ff && !ovr_clr);
            lvl_flag_ff <= lvl_hit || (lvl_flag_ff && !lvl_clr);
            lock_flag_ff <= lock_rise || (lock_flag_ff && !lock_clr);
            tx_done_ff <= evt.last_bit_out
                          || (tx_done_ff && !ovr_clr && !(tx_mode && !tx_mode_d_ff));
            tx_mode_d_ff <= tx_mode;
        end
    end

    // Fill state, status and outputs
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fill_state_ff <= RIF_FS_WAIT;
            status_ff <= RIF_EV_RST;
            rdata_ff <= 8'h00;
            pin_one_ff <= 1'b0;
            lock_pin_ff <= 1'b1;
            load_en_ff <= 1'b0;
            restart_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else
        begin
            fill_state_ff <= nxt_fill_state;
            status_ff <= nxt_status;
            rdata_ff <= bus_req.rd ? rd_mux : 8'h00;
            pin_one_ff <= nxt_pin_one;
            lock_pin_ff <= nxt_lock_pin;
            load_en_ff <= buffered && (nxt_fill_state == RIF_FS_LOAD);
            restart_ff <= ovr_clr;
            irq_ff <= |(status_ff & enable_ff);
        end
    end

    // Output drive
    assign rdata = rdata_ff;
    assign interrupt_pin_one = pin_one_ff;
    assign lock_detect_pin = lock_pin_ff;
    assign fifo_load_en = load_en_ff;
    assign restart = restart_ff;
    assign irq = irq_ff;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence seq_ovr_clear_req;
        ovr_clr && !evt.overrun;
    endsequence

    sequence seq_ovr_cleared;
        !ovr_ff && restart && fill_state_ff == RIF_FS_WAIT;
    endsequence

    chk_pin_one_full: assert property (
        tx_mode && !continuous && !tx_sel_ff |=> interrupt_pin_one == $past(fifo_full))
        else $error("Pin one does not follow FIFO full");
    chk_full_read: assert property (
        bus_req.rd && hit_cfg |=> rdata[RIF_FULL_BIT] == $past(fifo_full))
        else $error("FIFO full flag read wrong");
    chk_nempty_read: assert property (
        bus_req.rd && hit_cfg && fifo_state.count == 7'h00 |=> !rdata[RIF_NEMPTY_BIT])
        else $error("Not-empty flag high with empty FIFO");
    chk_auto_fill_start: assert property (
        fill_start && !ovr_clr |=> fill_state_ff == RIF_FS_LOAD && fifo_load_en)
        else $error("Auto fill did not start on sync");
    chk_fill_rearm: assert property (
        auto_fill && fill_wr1 && !ovr_ff && !fill_start |=> fill_state_ff == RIF_FS_WAIT)
        else $error("Fill bit not cleared by write");
    chk_manual_fill: assert property (
        manual_fill && wr_ctl && !ovr_clr |=> fill_bit == $past(bus_req.wdata[RIF_FILL_BIT]))
        else $error("Manual fill write not honoured");
    chk_tx_done_set: assert property (
        evt.last_bit_out |=> tx_done_ff && status_ff[RIF_EV_TX_DONE])
        else $error("Tx done flag not set");
    chk_ovr_set: assert property (
        evt.overrun |=> ovr_ff)
        else $error("Overrun flag not set");
    chk_ovr_clear: assert property (
        seq_ovr_clear_req |=> seq_ovr_cleared ##1 (!restart || $past(ovr_clr)))
        else $error("Overrun clear did not restart");
    chk_lvl_flag: assert property (
        lvl_hit |=> lvl_flag_ff ##1 lvl_flag_ff || $past(lvl_clr))
        else $error("Level flag not set above threshold");
    chk_lock_pin: assert property (
        !lock_en_ff |=> lock_detect_pin)
        else $error("Lock pin not high while disabled");
    chk_flag_hold: assert property (
        lock_flag_ff && !lock_clr |=> lock_flag_ff)
        else $error("Lock flag dropped without clear");
    chk_irq_level: assert property (
        |(status_ff & enable_ff) |=> irq)
        else $error("Interrupt not raised");
    chk_irq_low: assert property (
        !(|(status_ff & enable_ff)) |=> !irq)
        else $error("Interrupt raised with no enabled status");

    // Pin routing and readback
    chk_nempty_high: assert property (
        bus_req.rd && hit_cfg && fifo_state.count != 7'h00 |=> rdata[RIF_NEMPTY_BIT])
        else $error("Not-empty flag low with bytes held");
    chk_pin_one_idle: assert property (
        !tx_mode |=> !interrupt_pin_one)
        else $error("Pin one active outside transmit");
    chk_pin_one_recovered_data_clock: assert property (
        tx_mode && continuous |=> interrupt_pin_one == $past(recovered_data_clock))
        else $error("Pin one does not follow data clock");
    chk_pin_one_done: assert property (
        tx_mode && !continuous && tx_sel_ff |=> interrupt_pin_one == $past(tx_done_ff))
        else $error("Pin one does not follow tx done");
    chk_lock_pin_follow: assert property (
        lock_en_ff |=> lock_detect_pin == $past(lock_s2_ff))
        else $error("Lock pin does not follow lock");
    chk_rdata_idle: assert property (
        !bus_req.rd |=> rdata == 8'h00)
        else $error("Read data not idle");
    chk_thresh_write: assert property (
        wr_thr |=> thresh_ff == $past(bus_req.wdata))
        else $error("Threshold write lost");
    chk_auto_fill_hold: assert property (
        auto_fill && wr_ctl && !fill_wr1 && !fill_start && !ovr_clr |=> fill_state_ff == $past(fill_state_ff))
        else $error("Auto fill state moved by write of zero");

    // Sticky flags and their clears
    sequence seq_lock_edge;
        lock_s2_ff && !lock_d_ff;
    endsequence

    sequence seq_lock_flagged;
        lock_flag_ff && status_ff[RIF_EV_LOCK];
    endsequence

    chk_lock_set: assert property (
        seq_lock_edge |=> seq_lock_flagged)
        else $error("Lock flag not set on lock");
    chk_lock_clear: assert property (
        lock_clr && !lock_rise |=> !lock_flag_ff)
        else $error("Lock flag not cleared");
    chk_lvl_clear: assert property (
        lvl_clr && !lvl_hit |=> !lvl_flag_ff)
        else $error("Level flag not cleared");
    chk_lvl_gate: assert property (
        !lvl_en_ff |=> !$rose(lvl_flag_ff))
        else $error("Level flag set while source disabled");
    chk_ovr_hold: assert property (
        ovr_ff && !ovr_clr |=> ovr_ff)
        else $error("Overrun flag dropped without clear");
    chk_lvl_hold: assert property (
        lvl_flag_ff && !lvl_clr |=> lvl_flag_ff)
        else $error("Level flag dropped without clear");
    chk_status_sticky: assert property (
        status_ff[RIF_EV_OVR] && !(wr_clr && bus_req.wdata[RIF_EV_OVR]) |=> status_ff[RIF_EV_OVR])
        else $error("Overrun status dropped without clear");
    chk_restart_quiet: assert property (
        !ovr_clr |=> !restart)
        else $error("Restart without overrun clear");

endmodule

`default_nettype wire

/* File: hdl/rif_pkg.sv */
package rif_pkg;

    // Register addresses
    localparam logic [7:0] RIF_ADDR_SRC_CFG = 8'h0d;
    localparam logic [7:0] RIF_ADDR_STAT_CTL = 8'h0e;
    localparam logic [7:0] RIF_ADDR_THRESH = 8'h0f;
    localparam logic [7:0] RIF_ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] RIF_ADDR_IRQ_CLEAR = 8'h11;
    localparam logic [7:0] RIF_ADDR_IRQ_ENABLE = 8'h12;

    // Field positions in irq_source_config
    localparam int RIF_TX_SEL_BIT = 2;
    localparam int RIF_FULL_BIT = 1;
    localparam int RIF_NEMPTY_BIT = 0;

    // Field positions in irq_status_control
    localparam int RIF_FILL_METHOD_BIT = 7;
    localparam int RIF_FILL_BIT = 6;
    localparam int RIF_TX_DONE_BIT = 5;
    localparam int RIF_OVR_BIT = 4;
    localparam int RIF_LVL_EN_BIT = 3;
    localparam int RIF_LVL_FLAG_BIT = 2;
    localparam int RIF_LOCK_FLAG_BIT = 1;
    localparam int RIF_LOCK_EN_BIT = 0;

    // Event positions in the interrupt status, clear and enable registers
    localparam int RIF_EV_OVR = 0;
    localparam int RIF_EV_TX_DONE = 1;
    localparam int RIF_EV_LVL = 2;
    localparam int RIF_EV_LOCK = 3;
    localparam int RIF_EV_FILL = 4;
    localparam int RIF_NUM_EV = 5;

    // Reset values
    localparam logic [4:0] RIF_SRC_HI_RST = 5'h00;
    localparam logic RIF_TX_SEL_RST = 1'h0;
    localparam logic RIF_FILL_METHOD_RST = 1'h0;
    localparam logic RIF_LVL_EN_RST = 1'h0;
    localparam logic RIF_LOCK_EN_RST = 1'h1;
    localparam logic [7:0] RIF_THRESH_RST = 8'h00;
    localparam logic [4:0] RIF_EV_RST = 5'h00;

    // Data handling modes
    localparam logic [1:0] RIF_MODE_CONT = 2'h0;
    localparam logic [1:0] RIF_MODE_BUF = 2'h1;

    // FIFO fill states
    typedef enum logic [1:0] {
        RIF_FS_WAIT = 2'b01,
        RIF_FS_LOAD = 2'b10
    } rif_fill_state_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rif_bus_req_t;

    // FIFO occupancy from the data path
    typedef struct packed {
        logic [6:0] count;
        logic [6:0] capacity;
    } rif_fifo_t;

    // Single-cycle events from the data path
    typedef struct packed {
        logic sync_detect;
        logic overrun;
        logic last_bit_out;
    } rif_evt_t;

endpackage

/* File: dv/rif_dpath_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Data path model: a small FIFO that loads bytes while the block enables loading
module rif_dpath_model
    import rif_pkg::*;
#(
    parameter int CAP = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Controls from the block and the bench
    input wire logic fifo_load_en,
    input wire logic restart,
    input wire logic push,
    // Occupancy and overrun pulse
    output rif_fifo_t fifo_state,
    output logic overrun
);
    logic [6:0] cnt_ff;

    // Occupancy, configured size fixed by the parameter
    assign fifo_state = {cnt_ff, 7'(CAP)};

    // A restart empties the FIFO; a byte offered while full is lost
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_ff <= 7'h00;
            overrun <= 1'b0;
        end
        else
        begin
            overrun <= push && fifo_load_en && (cnt_ff == 7'(CAP));
            if (restart)
                cnt_ff <= 7'h00;
            else if (push && fifo_load_en && (cnt_ff < 7'(CAP)))
                cnt_ff <= cnt_ff + 7'h01;
        end
    end
endmodule
`default_nettype wire

/* File: dv/rif_irq_flags_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module rif_irq_flags_tb;
    import rif_pkg::*;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    rif_bus_req_t bus_req = '0;
    logic [7:0] rdata;
    logic [1:0] data_mode = RIF_MODE_BUF;
    logic tx_mode = 1'b0;
    logic bit_clk = 1'b0;
    logic [7:0] sig_lvl = 8'h00;
    logic lock_in = 1'b0;
    logic sync_p = 1'b0;
    logic last_p = 1'b0;
    logic push = 1'b0;
    logic pin1, lock_pin, load_en, restart, irq, ovr;
    rif_fifo_t fifo_state;
    rif_evt_t evt;
    int error_cnt = 0;
    int check_count = 0;

    // Clock, 8 ns period
    always #4 clk = ~clk;
    assign evt = '{sync_detect: sync_p, overrun: ovr, last_bit_out: last_p};

    rif_irq_flags rif_irq_flags_i (.clk(clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
        .data_mode(data_mode), .tx_mode(tx_mode), .recovered_data_clock(bit_clk), .fifo_state(fifo_state),
        .evt(evt), .signal_level(sig_lvl), .pll_lock_pin(lock_in), .interrupt_pin_one(pin1),
        .lock_detect_pin(lock_pin), .fifo_load_en(load_en), .restart(restart), .irq(irq));

    rif_dpath_model #(.CAP(4)) rif_dpath_model_i (.clk(clk), .rstn(rstn), .fifo_load_en(load_en),
        .restart(restart), .push(push), .fifo_state(fifo_state), .overrun(ovr));

    // Compare tasks for register values and pins
    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk1(input string nm, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %b seen %b", nm, exp, got);
        end
    endtask

    // Register port cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1;
        chk8("rdata", exp, rdata);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        test_done;
    end

    // Test sequence
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(RIF_ADDR_SRC_CFG, 8'h00);
        rd(RIF_ADDR_STAT_CTL, 8'h01);
        rd(RIF_ADDR_THRESH, 8'h00);
        wr(RIF_ADDR_THRESH, 8'ha5);
        rd(RIF_ADDR_THRESH, 8'ha5);
        rd(8'h20, 8'h00);
        $display("test reset done");
        // Manual fill to full, then overrun and its clear
        wr(RIF_ADDR_STAT_CTL, 8'h81);
        wr(RIF_ADDR_STAT_CTL, 8'hc1);
        @(posedge clk);
        push <= 1'b1;
        repeat (5) @(posedge clk);
        push <= 1'b0;
        rd(RIF_ADDR_SRC_CFG, 8'h03);
        rd(RIF_ADDR_STAT_CTL, 8'hd1);
        rd(RIF_ADDR_IRQ_STATUS, 8'h01);
        wr(RIF_ADDR_IRQ_ENABLE, 8'h1f);
        settle(2);
        chk1("irq", 1'b1, irq);
        wr(RIF_ADDR_STAT_CTL, 8'h91);
        #1;
        chk1("restart", 1'b1, restart);
        settle(2);
        chk1("fifo_load_en", 1'b0, load_en);
        rd(RIF_ADDR_SRC_CFG, 8'h00);
        rd(RIF_ADDR_STAT_CTL, 8'h81);
        wr(RIF_ADDR_IRQ_CLEAR, 8'h01);
        settle(2);
        chk1("irq", 1'b0, irq);
        $display("test manual fill done");
        // Automatic fill on sync word
        wr(RIF_ADDR_STAT_CTL, 8'h01);
        @(posedge clk);
        sync_p <= 1'b1;
        @(posedge clk);
        sync_p <= 1'b0;
        settle(3);
        chk1("fifo_load_en", 1'b1, load_en);
        rd(RIF_ADDR_STAT_CTL, 8'h41);
        rd(RIF_ADDR_IRQ_STATUS, 8'h10);
        wr(RIF_ADDR_STAT_CTL, 8'h41);
        settle(2);
        chk1("fifo_load_en", 1'b0, load_en);
        rd(RIF_ADDR_STAT_CTL, 8'h01);
        wr(RIF_ADDR_IRQ_CLEAR, 8'h1f);
        $display("test auto fill done");
        // Transmit pin source selection
        tx_mode <= 1'b1;
        settle(2);
        chk1("interrupt_pin_one", 1'b0, pin1);
        wr(RIF_ADDR_STAT_CTL, 8'h81);
        wr(RIF_ADDR_STAT_CTL, 8'hc1);
        @(posedge clk);
        push <= 1'b1;
        repeat (4) @(posedge clk);
        push <= 1'b0;
        settle(2);
        chk1("interrupt_pin_one", 1'b1, pin1);
        wr(RIF_ADDR_STAT_CTL, 8'h11);
        wr(RIF_ADDR_SRC_CFG, 8'h04);
        @(posedge clk);
        last_p <= 1'b1;
        @(posedge clk);
        last_p <= 1'b0;
        settle(3);
        chk1("interrupt_pin_one", 1'b1, pin1);
        rd(RIF_ADDR_STAT_CTL, 8'h21);
        rd(RIF_ADDR_IRQ_STATUS, 8'h02);
        @(posedge clk);
        data_mode <= RIF_MODE_CONT;
        settle(2);
        chk1("interrupt_pin_one", 1'b0, pin1);
        @(posedge clk);
        bit_clk <= 1'b1;
        settle(2);
        chk1("interrupt_pin_one", 1'b1, pin1);
        @(posedge clk);
        tx_mode <= 1'b0;
        $display("test tx pin done");
        // Signal level flag against threshold
        wr(RIF_ADDR_THRESH, 8'h40);
        wr(RIF_ADDR_STAT_CTL, 8'h09);
        sig_lvl <= 8'h40;
        settle(3);
        rd(RIF_ADDR_STAT_CTL, 8'h29);
        @(posedge clk);
        sig_lvl <= 8'h41;
        settle(3);
        @(posedge clk);
        sig_lvl <= 8'h10;
        rd(RIF_ADDR_STAT_CTL, 8'h2d);
        wr(RIF_ADDR_STAT_CTL, 8'h09);
        rd(RIF_ADDR_STAT_CTL, 8'h2d);
        wr(RIF_ADDR_STAT_CTL, 8'h0d);
        rd(RIF_ADDR_STAT_CTL, 8'h29);
        rd(RIF_ADDR_IRQ_STATUS, 8'h06);
        $display("test level done");
        // Synthesizer lock flag and pin
        chk1("lock_detect_pin", 1'b0, lock_pin);
        @(posedge clk);
        lock_in <= 1'b1;
        settle(4);
        chk1("lock_detect_pin", 1'b1, lock_pin);
        rd(RIF_ADDR_STAT_CTL, 8'h2b);
        @(posedge clk);
        lock_in <= 1'b0;
        settle(4);
        chk1("lock_detect_pin", 1'b0, lock_pin);
        wr(RIF_ADDR_STAT_CTL, 8'h0b);
        rd(RIF_ADDR_STAT_CTL, 8'h29);
        wr(RIF_ADDR_STAT_CTL, 8'h08);
        settle(2);
        chk1("lock_detect_pin", 1'b1, lock_pin);
        rd(RIF_ADDR_STAT_CTL, 8'h28);
        $display("test lock done");
        test_done;
    end
endmodule
`default_nettype wire
